// File: rtl/crm_pkg.sv
// Constants and types for the control register bank
package crm_pkg;

   //------------------------------------------------------------
   // Register slots
   //------------------------------------------------------------
   localparam int NREG = 32;
   localparam logic [4:0] S_P0 = 5'h00;
   localparam logic [4:0] S_P1 = 5'h01;
   localparam logic [4:0] S_P3 = 5'h03;
   localparam logic [4:0] S_CTR8 = 5'h04;
   localparam logic [4:0] S_CTR16 = 5'h05;
   localparam logic [4:0] S_CTR3RD = 5'h06;
   localparam logic [4:0] S_TL8L = 5'h08;
   localparam logic [4:0] S_TL8H = 5'h09;
   localparam logic [4:0] S_TL16L = 5'h0a;
   localparam logic [4:0] S_TL16H = 5'h0b;
   localparam logic [4:0] S_CAP16L = 5'h0c;
   localparam logic [4:0] S_CAP16H = 5'h0d;
   localparam logic [4:0] S_CAP8L = 5'h0e;
   localparam logic [4:0] S_CAP8H = 5'h0f;
   localparam logic [4:0] S_DRIVE = 5'h11;
   localparam logic [4:0] S_IRQ = 5'h19;
   localparam logic [4:0] S_P1DIR = 5'h1f;

   //------------------------------------------------------------
   // Register index per slot (byte address is four times it)
   //------------------------------------------------------------
   localparam logic [9:0] REG_IDX [NREG] = '{
      10'h000, 10'h001, 10'h002, 10'h003, 10'h100, 10'h101, 10'h102,
      10'h103, 10'h104, 10'h105, 10'h106, 10'h107, 10'h108, 10'h109,
      10'h10a, 10'h10b, 10'h10c, 10'h200, 10'h20b, 10'h20d, 10'h20f,
      10'h0f6, 10'h0f7, 10'h0f8, 10'h0f9, 10'h0fa, 10'h0fb, 10'h0fc,
      10'h0fd, 10'h0fe, 10'h0ff, 10'h010};

   // Power-on values per slot
   localparam logic [7:0] REG_POR [NREG] = '{
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h1f,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'hfe, 8'h20, 8'h00, 8'h0d, 8'hff, 8'h00, 8'hcf,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   // Bits kept through stop-mode recovery
   localparam logic [7:0] REG_KEEP [NREG] = '{
      8'h00, 8'hff, 8'h00, 8'h00, 8'h3e, 8'h30, 8'h3c, 8'h20,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'h00, 8'h00, 8'hfe, 8'hff, 8'h00, 8'hff, 8'hff, 8'h00,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   //------------------------------------------------------------
   // Field positions and synchroniser width
   //------------------------------------------------------------
   localparam int DRIVE_PP_BIT = 1;
   localparam int CTR8_P34_BIT = 0;
   localparam int CTR8_TOUT_BIT = 5;
   localparam int CTR3RD_P35_BIT = 0;
   localparam int SYNC_W = 12;

   typedef struct packed {
      logic [NREG-1:0][7:0] regs;
      logic [7:0]           p1_out;
      logic [7:0]           p1_oe;
      logic [3:0]           p3_out;
      logic [2:0]           p3_prev;
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
   } crm_state_t;

endpackage : crm_pkg

// File: rtl/crm_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
module crm_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Pins in, synchronised out
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   logic [W-1:0] meta;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule : crm_sync

// File: rtl/crm_top.sv
// Control register bank with port one and port three pin logic
module crm_top
   import crm_pkg::*;
(
   // APB slave
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Stop-mode recovery event
   input  wire logic        smr_event,
   // Timer events and capture data
   input  wire logic        t8_timeout,
   input  wire logic        t8_out,
   input  wire logic        t16_out,
   input  wire logic        cap8_hi_load,
   input  wire logic        cap8_lo_load,
   input  wire logic [7:0]  cap8_value,
   input  wire logic        cap16_load,
   input  wire logic [15:0] cap16_value,
   // Timer configuration out
   output logic      [7:0]  timer8_ctrl,
   output logic      [7:0]  timer16_ctrl,
   output logic      [15:0] timer8_load,
   output logic      [15:0] timer16_load,
   // Port one pins
   input  wire logic [7:0]  p1_in,
   output logic      [7:0]  p1_out,
   output logic      [7:0]  p1_oe,
   // Port three pins
   input  wire logic [3:0]  p3_in,
   output logic      [3:0]  p3_out
);

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   // Map a byte address to {miss, slot}
   function automatic logic [5:0] slot_of(input logic [11:0] a);
      logic [5:0] r;
      r = 6'h20;
      for (int i = 0; i < NREG; i++) begin
         if (a[1:0] == 2'h0 && a[11:2] == REG_IDX[i]) begin
            r = {1'b0, 5'(i)};
         end
      end
      return r;
   endfunction : slot_of

   function automatic crm_state_t por_state();
      crm_state_t s;
      s = '0;
      for (int i = 0; i < NREG; i++) begin
         s.regs[i] = REG_POR[i];
      end
      return s;
   endfunction : por_state

   localparam crm_state_t ST_POR = por_state();

   //------------------------------------------------------------
   // Pin synchronisers
   //------------------------------------------------------------
   logic [SYNC_W-1:0] pins_sync;
   logic [7:0]        p1_pin;
   logic [3:0]        p3_pin;

   crm_sync #(
      .W (SYNC_W)
   ) u_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .d       ({p3_in, p1_in}),
      .q       (pins_sync)
   );

   assign p1_pin = pins_sync[7:0];
   assign p3_pin = pins_sync[11:8];

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   crm_state_t st;
   crm_state_t next_st;

   logic [5:0] dec;
   logic       hit;
   logic [4:0] slot;
   logic       done;
   logic       wr_go;
   logic [7:0] wbyte;
   logic [7:0] rbyte;
   logic       push_pull;
   logic [7:0] dir;
   logic [7:0] cur;

   always_comb begin
      next_st = st;
      dec     = slot_of(paddr);
      hit     = ~dec[5];
      slot    = dec[4:0];
      wbyte   = pwdata[7:0];
      done    = psel & penable & st.pready;
      wr_go   = done & pwrite & pstrb[0] & ~st.pslverr;
      cur     = st.regs[slot];

      // Read value, port data mixes in pin levels
      rbyte = cur;
      if (slot == S_P1) begin
         rbyte = (cur & st.regs[S_P1DIR]) | (p1_pin & ~st.regs[S_P1DIR]);
      end else if (slot == S_P3) begin
         rbyte = {cur[7:4], p3_pin};
      end

      //---------------------------------------------------------
      // Bus handshake: setup arms a registered answer
      //---------------------------------------------------------
      if (done) begin
         next_st.pready  = 1'b0;
         next_st.pslverr = 1'b0;
      end else if (psel && !penable) begin
         next_st.pready  = 1'b1;
         next_st.pslverr = ~hit;
         next_st.prdata  = hit ? {24'h0, rbyte} : 32'h0;
      end

      //---------------------------------------------------------
      // Software writes
      //---------------------------------------------------------
      if (wr_go) begin
         case (slot)
            S_CAP8L, S_CAP8H, S_CAP16L, S_CAP16H: begin
               next_st.regs[slot] = cur;
            end
            S_CTR8: begin
               // Timeout status clears by writing one
               next_st.regs[S_CTR8] = wbyte;
               next_st.regs[S_CTR8][CTR8_TOUT_BIT] =
                  cur[CTR8_TOUT_BIT] & ~wbyte[CTR8_TOUT_BIT];
            end
            S_P1DIR: begin
               next_st.regs[S_P1DIR] = wbyte;
            end
            default: begin
               next_st.regs[slot] = wbyte;
            end
         endcase
      end

      //---------------------------------------------------------
      // Stop-mode recovery: keep flagged bits, rest to power-on
      //---------------------------------------------------------
      if (smr_event) begin
         for (int i = 0; i < NREG; i++) begin
            next_st.regs[i] = (next_st.regs[i] & REG_KEEP[i])
                            | (REG_POR[i] & ~REG_KEEP[i]);
         end
         // Port one direction register clears, no pin driven
         next_st.regs[S_P1DIR] = 8'h00;
      end

      //---------------------------------------------------------
      // Hardware events win over clears in the same cycle
      //---------------------------------------------------------
      if (t8_timeout) begin
         next_st.regs[S_CTR8][CTR8_TOUT_BIT] = 1'b1;
      end
      for (int i = 0; i < 3; i++) begin
         // Falling edge on input pins one to three
         if (st.p3_prev[i] && !p3_pin[i+1]) begin
            next_st.regs[S_IRQ][i] = 1'b1;
         end
      end
      next_st.p3_prev = p3_pin[3:1];
      if (cap8_hi_load) begin
         next_st.regs[S_CAP8H] = cap8_value;
      end
      if (cap8_lo_load) begin
         next_st.regs[S_CAP8L] = cap8_value;
      end
      if (cap16_load) begin
         next_st.regs[S_CAP16H] = cap16_value[15:8];
         next_st.regs[S_CAP16L] = cap16_value[7:0];
      end

      //---------------------------------------------------------
      // Port one drivers
      //---------------------------------------------------------
      push_pull = next_st.regs[S_DRIVE][DRIVE_PP_BIT];
      dir       = next_st.regs[S_P1DIR];
      if (push_pull) begin
         next_st.p1_out = next_st.regs[S_P1];
         next_st.p1_oe  = dir;
      end else begin
         next_st.p1_out = 8'h00;
         next_st.p1_oe  = dir & ~next_st.regs[S_P1];
      end

      //---------------------------------------------------------
      // Port three fixed push-pull outputs
      //---------------------------------------------------------
      next_st.p3_out[0] = next_st.regs[S_CTR8][CTR8_P34_BIT]
                        ? t8_out : next_st.regs[S_P3][4];
      next_st.p3_out[1] = next_st.regs[S_CTR3RD][CTR3RD_P35_BIT]
                        ? t16_out : next_st.regs[S_P3][5];
      next_st.p3_out[3:2] = next_st.regs[S_P3][7:6];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st <= ST_POR;
      end else begin
         st <= next_st;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   assign prdata       = st.prdata;
   assign pready       = st.pready;
   assign pslverr      = st.pslverr;
   assign p1_out       = st.p1_out;
   assign p1_oe        = st.p1_oe;
   assign p3_out       = st.p3_out;
   assign timer8_ctrl  = st.regs[S_CTR8];
   assign timer16_ctrl = st.regs[S_CTR16];
   assign timer8_load  = {st.regs[S_TL8H], st.regs[S_TL8L]};
   assign timer16_load = {st.regs[S_TL16H], st.regs[S_TL16L]};

endmodule : crm_top

// File: verif/crm_top_sva.sv
// Port-level assertions for the control register bank
module crm_top_sva (
   // Clock, reset and APB
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Recovery, timers and pins
   input wire logic        smr_event,
   input wire logic        t8_out,
   input wire logic [7:0]  timer8_ctrl,
   input wire logic [7:0]  timer16_ctrl,
   input wire logic [15:0] timer16_load,
   input wire logic [7:0]  p1_oe,
   input wire logic [3:0]  p3_out
);
   logic wr;
   assign wr = psel && penable && pwrite;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Recovery with no write beside it
   sequence quiet_smr;
      smr_event && !wr ##1 !wr;
   endsequence
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_access: assert property (
      psel && !penable ##1 psel && penable |-> pready)
      else $error("no answer in first access cycle");
   a_ready_phase: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_zero: assert property (
      pslverr |-> pready && prdata == 32'h0)
      else $error("error answer with data or without ready");
   a_dir_recover: assert property (quiet_smr |=> p1_oe == 8'h00)
      else $error("port one still driven after recovery");
   a_ctrl8_clear: assert property (
      quiet_smr |=> (timer8_ctrl & 8'hc1) == 8'h00)
      else $error("timer8 bits kept");
   a_ctrl16_clear: assert property (
      quiet_smr |=> (timer16_ctrl & 8'hcf) == 8'h00)
      else $error("timer16 bits kept");
   a_load_keep: assert property (
      quiet_smr |-> $stable(timer16_load) ##1 $stable(timer16_load))
      else $error("timer load lost on recovery");
   a_p3_route: assert property (
      timer8_ctrl[0] && $past(timer8_ctrl[0]) && $stable(t8_out)
      |-> p3_out[0] == t8_out)
      else $error("timer output not on port three");
   c_recover: cover property (smr_event);
   c_error: cover property (pslverr);
   c_route: cover property (timer8_ctrl[0] && !p3_out[0]);
endmodule : crm_top_sva

bind crm_top crm_top_sva u_sva (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .smr_event(smr_event),
   .t8_out(t8_out), .timer8_ctrl(timer8_ctrl), .timer16_ctrl(timer16_ctrl),
   .timer16_load(timer16_load), .p1_oe(p1_oe), .p3_out(p3_out));

// File: verif/crm_top_test.sv
// Self-checking bench for the control register bank
module crm_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic        smr_event, cap8_hi_load, cap8_lo_load, t8_out, t8_timeout;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, seed, r;
   logic [7:0]  cap8_value, p1_in, p1_out, p1_oe, v1, v2, ev;
   logic [3:0]  p3_in, p3_out;
   logic [15:0] t8_load;
   logic [32:0] exp_q[$];
   logic [7:0]  wv[13];
   int          n_mismatch, compares;
   // Index, kept bits, power-on value
   localparam logic [25:0] TB [13] = '{
      {10'h100, 8'h3e, 8'h00}, {10'h101, 8'h30, 8'h00},
      {10'h102, 8'h3c, 8'h00}, {10'h103, 8'h20, 8'h1f},
      {10'h20b, 8'hfe, 8'h20}, {10'h104, 8'hff, 8'h00},
      {10'h107, 8'hff, 8'h00}, {10'h20d, 8'hff, 8'h00},
      {10'h0f6, 8'hff, 8'hff}, {10'h0f7, 8'hff, 8'h00},
      {10'h0f8, 8'h00, 8'hcf}, {10'h200, 8'h00, 8'hfe},
      {10'h010, 8'h00, 8'h00}};

   crm_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .smr_event,
      .t8_timeout, .t8_out, .t16_out(1'b0), .cap8_hi_load,
      .cap8_lo_load, .cap8_value, .cap16_load(1'b0),
      .cap16_value(16'h0000), .timer8_ctrl(), .timer16_ctrl(),
      .timer8_load(t8_load), .timer16_load(), .p1_in, .p1_out, .p1_oe,
      .p3_in,
      .p3_out);

   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   task automatic chk(input string nm, input logic [32:0] s, e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic final_report();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : final_report

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick

   task automatic xfer(input logic [9:0] idx, input logic w,
                       input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         if (n > 20) begin
            n_mismatch++;
            final_report();
         end
      end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic rd(input logic [9:0] idx, input logic err,
                     input logic [7:0] e);
      exp_q.push_back({err, 24'h000000, e});
      xfer(idx, 1'b0, 8'h00);
   endtask : rd

   //------------------------------------------------------------
   // Read answers against noted expectations
   //------------------------------------------------------------
   always @(posedge pclk) begin
      if (pready === 1'b1 && pwrite === 1'b0) begin
         if (exp_q.size() > 0)
            chk("apb read", {pslverr, prdata}, exp_q.pop_front());
         else
            n_mismatch++;
      end
   end

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   initial begin
      tick(20000);
      n_mismatch++;
      final_report();
   end

   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, smr_event} = 5'h00;
      {cap8_hi_load, cap8_lo_load, t8_out, t8_timeout} = 4'h0;
      {paddr, pwdata, cap8_value, p3_in} = '0;
      {n_mismatch, compares} = '0;
      seed = 32'haf327582;
      r = xs();
      p1_in = r[7:0];
      tick(20);
      presetn <= 1'b1;
      for (int i = 0; i < 13; i++)
         rd(TB[i][25:16], 1'b0, TB[i][7:0]);
      rd(10'h3ff, 1'b1, 8'h00);
      r = xs();
      xfer(10'h10a, 1'b1, r[7:0]);
      rd(10'h10a, 1'b0, 8'h00);
      v1 = r[15:8];
      v2 = r[23:16];
      cap8_value <= v1;
      cap8_hi_load <= 1'b1;
      @(posedge pclk);
      cap8_value <= v2;
      cap8_hi_load <= 1'b0;
      cap8_lo_load <= 1'b1;
      @(posedge pclk);
      cap8_lo_load <= 1'b0;
      rd(10'h10b, 1'b0, v1);
      rd(10'h10a, 1'b0, v2);
      for (int i = 0; i < 13; i++) begin
         r = xs();
         wv[i] = r[7:0];
         xfer(TB[i][25:16], 1'b1, wv[i]);
      end
      // Timeout status is set by hardware only
      t8_timeout <= 1'b1;
      @(posedge pclk);
      t8_timeout <= 1'b0;
      wv[0][5] = 1'b1;
      xfer(10'h001, 1'b1, 8'h5a);
      xfer(10'h200, 1'b1, 8'h02);
      xfer(10'h010, 1'b1, 8'h0f);
      tick(2);
      chk("p1 push-pull", 33'({p1_oe, p1_out}), 33'h00f5a);
      rd(10'h001, 1'b0, {p1_in[7:4], 4'ha});
      xfer(10'h200, 1'b1, 8'h00);
      tick(2);
      chk("p1 open-drain", 33'({p1_oe, p1_out}), 33'h00500);
      smr_event <= 1'b1;
      @(posedge pclk);
      smr_event <= 1'b0;
      tick(2);
      chk("p1 recovered", 33'(p1_oe), 33'h000);
      for (int i = 0; i < 13; i++) begin
         ev = (wv[i] & TB[i][15:8]) | (TB[i][7:0] & ~TB[i][15:8]);
         rd(TB[i][25:16], 1'b0, ev);
      end
      rd(10'h10b, 1'b0, v1);
      chk("timer8 load", 33'(t8_load), 33'(wv[5]));
      p3_in <= 4'hf;
      tick(4);
      p3_in <= 4'h0;
      tick(4);
      rd(10'h0fa, 1'b0, 8'h07);
      xfer(10'h003, 1'b1, 8'hb0);
      tick(2);
      chk("p3 pins", 33'(p3_out), 33'h00b);
      rd(10'h003, 1'b0, 8'hb0);
      xfer(10'h100, 1'b1, 8'h01);
      tick(3);
      chk("p3 timer route", 33'(p3_out), 33'h00a);
      // Drive all of port one, then reset in mid-run
      xfer(10'h010, 1'b1, 8'hff);
      presetn <= 1'b0;
      tick(2);
      presetn <= 1'b1;
      tick(2);
      chk("p1 after reset", 33'({p1_oe, p1_out}), 33'h0);
      rd(10'h010, 1'b0, 8'h00);
      final_report();
   end
endmodule : crm_top_test
